// ==== hw/sbt_pkg.sv ====
// Shared constants for the SRAM boundary-scan test access logic.
package sbt_pkg;
	localparam int IR_WIDTH   = 3;
	localparam int ID_WIDTH   = 32;
	localparam int BSR_LENGTH = 72;
	// Instruction codes.
	localparam logic [2:0] INS_EXTEST  = 3'h0;
	localparam logic [2:0] INS_IDCODE  = 3'h1;
	localparam logic [2:0] INS_SAMPLEZ = 3'h2;
	localparam logic [2:0] INS_SAMPLE  = 3'h4;
	localparam logic [2:0] INS_BYPASS  = 3'h7;
	localparam logic [2:0] IR_RESET    = INS_IDCODE;
	// Identification word field positions.
	localparam int ID_REV_LSB    = 28;
	localparam int ID_DEPTH_LSB  = 23;
	localparam int ID_WIDTH_LSB  = 18;
	localparam int ID_DEV_LSB    = 12;
	localparam int ID_VENDOR_LSB = 1;
	localparam logic ID_PRESENT  = 1'b1;
	// Test port timing.
	localparam int TCK_PERIOD_NS  = 100;
	localparam int CORE_PERIOD_NS = 25;
	localparam int TCK_MIN_CYCLES = (TCK_PERIOD_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
	// Test port states, Gray coded along the data register shift path.
	typedef enum logic [3:0] {
		ST_RESET   = 4'h0,
		ST_IDLE    = 4'h1,
		ST_SEL_DR  = 4'h3,
		ST_CAP_DR  = 4'h2,
		ST_SH_DR   = 4'h6,
		ST_EX1_DR  = 4'h7,
		ST_PA_DR   = 4'h5,
		ST_EX2_DR  = 4'h4,
		ST_UPD_DR  = 4'hC,
		ST_SEL_IR  = 4'hD,
		ST_CAP_IR  = 4'hF,
		ST_SH_IR   = 4'hE,
		ST_EX1_IR  = 4'hA,
		ST_PA_IR   = 4'hB,
		ST_EX2_IR  = 4'h9,
		ST_UPD_IR  = 4'h8
	} sbt_state_e;
endpackage : sbt_pkg

// ==== hw/sbt_tap_fsm.sv ====
// Test port state machine advanced by qualified test clock rising edges.
`timescale 1ns/1ps
module sbt_tap_fsm (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              rst,
	// Qualified edge and mode select
	input  wire logic              tck_rise,
	input  wire logic              tms,
	// State
	output sbt_pkg::sbt_state_e    state
);
	sbt_pkg::sbt_state_e next_state;

	always_comb begin
		unique case (state)
			sbt_pkg::ST_RESET:  next_state = tms ? sbt_pkg::ST_RESET  : sbt_pkg::ST_IDLE;
			sbt_pkg::ST_IDLE:   next_state = tms ? sbt_pkg::ST_SEL_DR : sbt_pkg::ST_IDLE;
			sbt_pkg::ST_SEL_DR: next_state = tms ? sbt_pkg::ST_SEL_IR : sbt_pkg::ST_CAP_DR;
			sbt_pkg::ST_CAP_DR: next_state = tms ? sbt_pkg::ST_EX1_DR : sbt_pkg::ST_SH_DR;
			sbt_pkg::ST_SH_DR:  next_state = tms ? sbt_pkg::ST_EX1_DR : sbt_pkg::ST_SH_DR;
			sbt_pkg::ST_EX1_DR: next_state = tms ? sbt_pkg::ST_UPD_DR : sbt_pkg::ST_PA_DR;
			sbt_pkg::ST_PA_DR:  next_state = tms ? sbt_pkg::ST_EX2_DR : sbt_pkg::ST_PA_DR;
			sbt_pkg::ST_EX2_DR: next_state = tms ? sbt_pkg::ST_UPD_DR : sbt_pkg::ST_SH_DR;
			sbt_pkg::ST_UPD_DR: next_state = tms ? sbt_pkg::ST_SEL_DR : sbt_pkg::ST_IDLE;
			sbt_pkg::ST_SEL_IR: next_state = tms ? sbt_pkg::ST_RESET  : sbt_pkg::ST_CAP_IR;
			sbt_pkg::ST_CAP_IR: next_state = tms ? sbt_pkg::ST_EX1_IR : sbt_pkg::ST_SH_IR;
			sbt_pkg::ST_SH_IR:  next_state = tms ? sbt_pkg::ST_EX1_IR : sbt_pkg::ST_SH_IR;
			sbt_pkg::ST_EX1_IR: next_state = tms ? sbt_pkg::ST_UPD_IR : sbt_pkg::ST_PA_IR;
			sbt_pkg::ST_PA_IR:  next_state = tms ? sbt_pkg::ST_EX2_IR : sbt_pkg::ST_PA_IR;
			sbt_pkg::ST_EX2_IR: next_state = tms ? sbt_pkg::ST_UPD_IR : sbt_pkg::ST_SH_IR;
			sbt_pkg::ST_UPD_IR: next_state = tms ? sbt_pkg::ST_SEL_DR : sbt_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state <= sbt_pkg::ST_RESET;
		end else if (tck_rise) begin
			state <= next_state;
		end
	end
endmodule : sbt_tap_fsm

// ==== hw/sbt_tap.sv ====
// Boundary-scan test access logic of a burst SRAM, sampled on the core clock.
`timescale 1ns/1ps
module sbt_tap #(
	parameter int         BSR_LEN   = sbt_pkg::BSR_LENGTH,
	parameter logic [3:0]  REVISION  = 4'h0,
	parameter logic [4:0]  DEPTH     = 5'h00,
	parameter logic [4:0]  WIDTH     = 5'h00,
	parameter logic [5:0]  DEVICE    = 6'h00,
	// Arbitrary vendor value.
	parameter logic [10:0] VENDOR    = 11'h5A5
) (
	// Core clock and reset
	input  wire logic               CORE_CLK,
	input  wire logic               RST,
	// Test port pins
	input  wire logic               TCK,
	input  wire logic               TMS,
	input  wire logic               TDI,
	input  wire logic               TRST,
	output logic                    TDO,
	output logic                    TDO_OE,
	// I/O ring
	input  wire logic [BSR_LEN-1:0] RING_IN,
	// Memory output drivers off
	output logic                    MEM_HIZ,
	// Current instruction
	output logic [2:0]              INSTR
);
	logic [2:0]          tck_sync;
	logic [1:0]          tms_sync;
	logic [1:0]          tdi_sync;
	logic [1:0]          trst_sync;
	logic [BSR_LEN-1:0]  ring_meta;
	logic [BSR_LEN-1:0]  ring_sync;
	logic                tck_rise;
	logic                tck_fall;
	sbt_pkg::sbt_state_e state;
	logic [2:0]          ir_shift;
	logic [2:0]          ir;
	logic [31:0]         id_shift;
	logic                bypass;
	logic [BSR_LEN-1:0]  bsr;
	logic                bsr_sel;
	logic                serial_out;
	logic [31:0]         id_word;

	// TCK passes two flip-flops; the third stage only keeps the last level to find edges.
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			tck_sync <= 3'h0;
		end else begin
			tck_sync <= {tck_sync[1:0], TCK};
		end
	end

	// TMS and TDI take the same two stages as TCK, so they line up with the edge they go with.
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			tms_sync <= 2'h3;
			tdi_sync <= 2'h0;
		end else begin
			tms_sync <= {tms_sync[0], TMS};
			tdi_sync <= {tdi_sync[0], TDI};
		end
	end

	// Test reset pin, two stages like every other link input.
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			trst_sync <= 2'h0;
		end else begin
			trst_sync <= {trst_sync[0], TRST};
		end
	end

	// The ring is synchronised as a vector; a moving pin may still capture either value.
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			ring_meta <= '0;
			ring_sync <= '0;
		end else begin
			ring_meta <= RING_IN;
			ring_sync <= ring_meta;
		end
	end

	assign tck_rise = tck_sync[1] & ~tck_sync[2];
	assign tck_fall = ~tck_sync[1] & tck_sync[2];

	sbt_tap_fsm i_sbt_tap_fsm (
		.clk      (CORE_CLK),
		.rst      (RST | trst_sync[1]),
		.tck_rise (tck_rise),
		.tms      (tms_sync[1]),
		.state    (state)
	);

	// Instructions that place the scan chain between TDI and TDO.
	function automatic logic chain_is_bsr(input logic [2:0] code);
		return (code == sbt_pkg::INS_EXTEST) || (code == sbt_pkg::INS_SAMPLEZ)
			|| (code == sbt_pkg::INS_SAMPLE);
	endfunction : chain_is_bsr

	// Reserved codes fall through to the bypass bit, so TDO never follows a stale register.
	function automatic logic chain_is_bypass(input logic [2:0] code);
		return (code != sbt_pkg::INS_IDCODE) && !chain_is_bsr(code);
	endfunction : chain_is_bypass

	// Only these two instructions take the memory output drivers away from the core.
	function automatic logic outputs_off(input logic [2:0] code);
		return (code == sbt_pkg::INS_EXTEST) || (code == sbt_pkg::INS_SAMPLEZ);
	endfunction : outputs_off

	assign id_word = {REVISION, DEPTH, WIDTH, DEVICE, VENDOR, sbt_pkg::ID_PRESENT};
	assign bsr_sel = chain_is_bsr(ir);

	// Instruction register: shift path and update latch.
	always_ff @(posedge CORE_CLK) begin
		if (RST || trst_sync[1]) begin
			ir_shift <= sbt_pkg::IR_RESET;
			ir       <= sbt_pkg::IR_RESET;
		end else if (state == sbt_pkg::ST_RESET) begin
			// Held for as long as the port rests in test-logic-reset, not only on an edge there.
			ir <= sbt_pkg::IR_RESET;
		end else if (tck_rise) begin
			unique case (state)
				sbt_pkg::ST_CAP_IR: ir_shift <= 3'h1;
				sbt_pkg::ST_SH_IR:  ir_shift <= {tdi_sync[1], ir_shift[2:1]};
				sbt_pkg::ST_UPD_IR: ir <= ir_shift;
				default: ;
			endcase
		end
	end

	// Identification word: loaded in Capture-DR, shifted toward TDO in Shift-DR.
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			id_shift <= '0;
		end else if (tck_rise && (ir == sbt_pkg::INS_IDCODE)) begin
			unique case (state)
				sbt_pkg::ST_CAP_DR: id_shift <= id_word;
				sbt_pkg::ST_SH_DR:  id_shift <= {tdi_sync[1], id_shift[31:1]};
				default: ;
			endcase
		end
	end

	// Bypass bit: captures zero, then passes TDI on with one stage of delay.
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			bypass <= 1'b0;
		end else if (tck_rise && chain_is_bypass(ir)) begin
			unique case (state)
				sbt_pkg::ST_CAP_DR: bypass <= 1'b0;
				sbt_pkg::ST_SH_DR:  bypass <= tdi_sync[1];
				default: ;
			endcase
		end
	end

	// Scan chain: the captured ring leaves with ring bit 0 first.
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			bsr <= '0;
		end else if (tck_rise && bsr_sel) begin
			unique case (state)
				sbt_pkg::ST_CAP_DR: bsr <= ring_sync;
				sbt_pkg::ST_SH_DR:  bsr <= {tdi_sync[1], bsr[BSR_LEN-1:1]};
				// With no preload stage, Update-DR holds the chain just as Pause-DR does.
				sbt_pkg::ST_PA_DR, sbt_pkg::ST_UPD_DR: bsr <= bsr;
				default: ;
			endcase
		end
	end

	// During Shift-IR the instruction path wins over whichever data register is selected.
	always_comb begin
		if (state == sbt_pkg::ST_SH_IR) begin
			serial_out = ir_shift[0];
		end else if (ir == sbt_pkg::INS_IDCODE) begin
			serial_out = id_shift[0];
		end else if (bsr_sel) begin
			serial_out = bsr[0];
		end else begin
			serial_out = bypass;
		end
	end

	// TDO changes on the falling test clock edge, as the far end samples on the rising.
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			TDO    <= 1'b0;
			TDO_OE <= 1'b0;
		end else if (trst_sync[1]) begin
			// A test reset releases the pin at once instead of at the next falling edge.
			TDO_OE <= 1'b0;
		end else if (tck_fall) begin
			TDO    <= serial_out;
			TDO_OE <= (state == sbt_pkg::ST_SH_DR) || (state == sbt_pkg::ST_SH_IR);
		end
	end

	// Both follow the active instruction one clock later, so they never disagree.
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			MEM_HIZ <= 1'b0;
			INSTR   <= sbt_pkg::IR_RESET;
		end else begin
			MEM_HIZ <= outputs_off(ir);
			INSTR   <= ir;
		end
	end
endmodule : sbt_tap

// ==== testbench/sbt_tap_chk.sv ====
// Port checker for the boundary-scan test logic.
`timescale 1ns/1ps
module sbt_tap_chk (
	// Watched ports
	input wire logic       CORE_CLK,
	input wire logic       RST,
	input wire logic       TCK,
	input wire logic       TRST,
	input wire logic       TDO,
	input wire logic       TDO_OE,
	input wire logic       MEM_HIZ,
	input wire logic [2:0] INSTR
);
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (RST);
	a_hiz_extest: assert property (INSTR == 3'h0 |-> MEM_HIZ) else $error("hiz 000");
	a_hiz_samplez: assert property (INSTR == 3'h2 |-> MEM_HIZ) else $error("hiz 010");
	a_hiz_only: assert property (MEM_HIZ |-> INSTR inside {3'h0, 3'h2}) else $error("hiz");
	a_reset_idcode: assert property (disable iff (1'b0) RST |=> INSTR == 3'h1 && !MEM_HIZ)
		else $error("reset");
	a_trst_idcode: assert property (TRST [*6] |-> INSTR == 3'h1) else $error("trst");
	a_tdo_fall: assert property ($changed(TDO) |-> !$past(TCK)) else $error("tdo");
	a_oe_hold: assert property ($rose(TDO_OE) |-> TDO_OE [*4]) else $error("oe");
	a_instr_quiet: assert property ($changed(INSTR) |-> !TDO_OE) else $error("ir");
	c_extest: cover property (INSTR == 3'h0 && TDO_OE);
	c_bypass: cover property (INSTR == 3'h7 && TDO_OE);
	c_trst: cover property (TRST [*6]);
endmodule : sbt_tap_chk
bind sbt_tap sbt_tap_chk i_sbt_tap_chk (.CORE_CLK(CORE_CLK), .RST(RST), .TCK(TCK),
	.TRST(TRST), .TDO(TDO), .TDO_OE(TDO_OE), .MEM_HIZ(MEM_HIZ), .INSTR(INSTR));

// ==== testbench/sbt_ctl_model.sv ====
// Test controller model that drives the five-wire test port.
`timescale 1ns/1ps
module sbt_ctl_model (
	// Core clock paces the test clock
	input  wire logic clk,
	// Test port
	output logic      tck,
	output logic      tms,
	output logic      tdi,
	output logic      trst,
	input  wire logic tdo,
	input  wire logic tdo_oe
);
	initial {tck, tms, tdi, trst} = 4'h4;
	// One 200 ns test clock period that rests low between calls. TDO is read mid-high phase,
	// where it cannot be moving. An undriven pin reads inverted, so a read outside a shift
	// shows up as a mismatch.
	task automatic step(input logic m, input logic d, output logic q);
		tms <= m;
		tdi <= d;
		repeat (2) @(posedge clk);
		tck <= 1'b1;
		repeat (2) @(posedge clk);
		q = tdo_oe ? tdo : ~tdo;
		repeat (2) @(posedge clk);
		tck <= 1'b0;
		repeat (2) @(posedge clk);
	endtask : step
	task automatic test_reset();
		trst <= 1'b1;
		repeat (8) @(posedge clk);
		trst <= 1'b0;
		repeat (4) @(posedge clk);
	endtask : test_reset
endmodule : sbt_ctl_model

// ==== testbench/tb.sv ====
// Self-checking bench for the boundary-scan test logic.
`timescale 1ns/1ps
module tb;
	localparam logic [71:0] RING = 72'hC3_5A96_0FF1_2E4D_B78A;
	// Arbitrary vendor value.
	localparam logic [10:0] VEND = 11'h2B4;
	logic        clk;
	logic        rst;
	logic        tck, tms, tdi, trst, tdo, oe, hiz;
	logic [2:0]  ins;
	logic [71:0] ring;
	int          miscompares;
	int          total_checks;
	sbt_tap #(.REVISION(4'h3), .DEPTH(5'h13), .WIDTH(5'h09), .VENDOR(VEND)) i_sbt_tap (
		.CORE_CLK(clk), .RST(rst), .TCK(tck), .TMS(tms), .TDI(tdi), .TRST(trst), .TDO(tdo),
		.TDO_OE(oe), .RING_IN(ring), .MEM_HIZ(hiz), .INSTR(ins));
	sbt_ctl_model i_sbt_ctl_model (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi), .trst(trst),
		.tdo(tdo), .tdo_oe(oe));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic chk(input logic [72:0] seen, input logic [72:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic walk(input int n, input logic [3:0] pat);
		logic q;
		for (int i = 0; i < n; i++) i_sbt_ctl_model.step(pat[i], 1'b0, q);
	endtask : walk
	// From idle into a shift state, n bits, then back to idle through update.
	task automatic scan(input int lead, input logic [72:0] din, input int n,
		output logic [72:0] dout);
		walk(lead, (lead == 4) ? 4'h3 : 4'h1);
		for (int i = 0; i < n; i++) begin
			i_sbt_ctl_model.step(i == n - 1, din[i], dout[i]);
			if (i == 0) chk(oe, 1'b1);
		end
		walk(2, 4'h1);
		chk(oe, 1'b0);
	endtask : scan
	task automatic tally_and_finish();
		$display("Checks %0d, mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : tally_and_finish
	initial begin
		#200us;
		miscompares++;
		tally_and_finish();
	end
	initial begin
		logic [72:0] o;
		logic [2:0]  c;
		rst = 1'b1;
		ring = RING;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		// The second pass reads the identification word again after a test reset.
		for (int r = 0; r < 2; r++) begin
			chk({hiz, ins}, 4'h1);
			walk(1, 4'h0);
			scan(3, '0, 32, o);
			chk(o[31:0], {4'h3, 5'h13, 5'h09, 6'h00, VEND, 1'b1});
			// Only documented codes are loaded; the ring moves so each capture is fresh.
			for (int k = 0; r == 0 && k < 4; k++) begin
				c = (k == 3) ? 3'h7 : 3'(2 * k);
				ring <= RING ^ {72{k[0]}};
				scan(4, {70'h0, c}, 3, o);
				chk(o[2:0], 3'h1);
				scan(3, {1'b1, ~RING}, 73, o);
				chk(c == 3'h7 ? o : o[71:0], c == 3'h7 ? {~RING, 1'b0} : {1'b0, ring});
				chk({hiz, ins}, {!c[0] && !c[2], c});
			end
			i_sbt_ctl_model.test_reset();
		end
		tally_and_finish();
	end
endmodule : tb
